// [fsp_buf.sv]
// sector byte buffer: 64 bytes, one write port, registered read port
`timescale 1ns/1ps
module fsp_buf (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [fsp_pkg::FSP_OFS_W-1:0] i_waddr,
    input wire logic [fsp_pkg::FSP_DATA_W-1:0] i_wdata,
    input wire logic [fsp_pkg::FSP_OFS_W-1:0] i_raddr,
    output logic [fsp_pkg::FSP_DATA_W-1:0] o_rdata
);
    import fsp_pkg::*;

    typedef struct packed {
        logic [FSP_SECTOR_BYTES-1:0][FSP_DATA_W-1:0] mem;
        logic [FSP_DATA_W-1:0] rdata;
    } fsp_buf_st_t;

    fsp_buf_st_t r;
    fsp_buf_st_t n;

    // ========================================================
    // next state: write one byte, read one byte a cycle later
    always_comb begin
        n = r;
        if (i_we) begin
            n.mem[i_waddr] = i_wdata;
        end
        n.rdata = r.mem[i_raddr];
    end

    // ========================================================
    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_rdata = r.rdata;
endmodule

// [fsp_flash_model.sv]
// behavioural byte-wide flash device facing the host sequencer
`timescale 1ns/1ps
module fsp_flash_model
    import fsp_pkg::*;
#(
    parameter logic [7:0] P_MAKER_ID = 8'h3C, // arbitrary value
    parameter logic [7:0] P_DEV_ID = 8'hC3, // arbitrary value
    parameter int P_BUSY_NS = 5000
) (
    input wire logic [14:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_viol
);
    logic [7:0] mem [0:32767];
    logic [7:0] page [0:63];
    logic [1:0] seq;
    logic loading, id_mode, busy, tog, polled;
    logic [6:0] nld;
    logic [8:0] sec;
    logic [14:0] poll_a;
    logic [7:0] last;
    realtime t_last;
    wire rd = !i_cs_n && !i_oe_n && i_we_n;
    wire [7:0] rd_val = busy ? {1'b0, tog, 6'h00} :
        id_mode ? (i_addr[0] ? P_DEV_ID : P_MAKER_ID) : mem[i_addr];

    // ========================================================
    // power-up: array reads, write-protected, id mode off
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        id_mode = 1'b0;
        loading = 1'b0;
        seq = 2'd0;
        busy = 1'b0;
        tog = 1'b1;
        polled = 1'b0;
        nld = 7'd0;
        o_viol = 1'b0;
        last = 8'h00;
    end

    // ========================================================
    // bytes latch on the falling write strobe; oe must be high
    always @(negedge i_we_n) begin
        // host moves data on the strobe edge itself; let the pins settle
        #1;
        if (!i_cs_n && i_oe_n && !busy) begin
            if (loading) begin
                if (nld == 7'd0)
                    sec = i_addr[14:6];
                if (i_addr[14:6] !== sec)
                    o_viol = 1'b1;
                if (nld != 7'd0 && $realtime - t_last > 150000.0)
                    o_viol = 1'b1;
                page[i_addr[5:0]] = i_dq;
                t_last = $realtime;
                nld = nld + 7'd1;
                if (nld == 7'd64) begin
                    loading = 1'b0;
                    busy = 1'b1;
                end
            end else if (i_addr == FSP_CMD_ADDR1 && i_dq == FSP_CMD_DAT1) begin
                seq = 2'd1;
            end else if (seq == 2'd1 && i_addr == FSP_CMD_ADDR2 &&
                         i_dq == FSP_CMD_DAT2) begin
                seq = 2'd2;
            end else if (seq == 2'd2 && i_addr == FSP_CMD_ADDR1) begin
                loading = (i_dq == FSP_CMD_PROG);
                if (i_dq == FSP_CMD_ID_ENTRY)
                    id_mode = 1'b1;
                if (i_dq == FSP_CMD_ID_EXIT)
                    id_mode = 1'b0;
                seq = 2'd0;
                nld = 7'd0;
            end else begin
                seq = 2'd0;
            end
        end
    end

    // ========================================================
    // program cycle: unloaded places end up unknown
    always @(posedge busy) begin
        #(P_BUSY_NS);
        for (int j = 0; j < 64; j++)
            mem[{sec, 6'(j)}] = page[j];
        foreach (page[j]) page[j] = 8'hXX;
        busy = 1'b0;
    end

    // each read start while busy flips bit 6, by cs or oe alike
    always @(posedge rd) begin
        // address moves on the same edge as the strobes
        #1;
        if (busy)
            tog = ~tog;
        if (busy && polled && i_addr !== poll_a)
            o_viol = 1'b1;
        polled = busy;
        poll_a = i_addr;
    end

    // a released bus shows the inverse, so stale data never passes
    always @(negedge rd) last = rd_val;
    assign o_dq = rd ? rd_val : ~last;
endmodule

// [fsp_host.sv]
// host sequencer driving a byte-wide flash: sector program, read, id
`timescale 1ns/1ps
// Contract
// [RULE1] each byte load carries the target sector on sector_address_lines.
// [RULE2] all 64 sector bytes are loaded; unloaded bytes end indeterminate.
// [RULE3] device re-protects after a program; every program re-sends unlock.
// [RULE4] successive byte loads start within 150 us of each other.
// [RULE5] toggle polling works with output_drive_n, chip_select_n or both.
// [RULE6] only a change of busy_toggle_line between reads has meaning.
// [RULE7] polling reads keep one constant address.
// [RULE8] device leaves id mode at power loss and starts in normal read.
// [RULE9] id mode: id_select_line low gives maker code, high device code.
// [RULE10] the id exit sequence returns the device to array reads.
// [RULE11] busy_toggle_line inverts per read while busy, stops when done.
// [RULE12] read: cs and oe low, we high; load: cs and we low, oe high.
// [RULE13] no new read or program until completion is seen by polling; after WC_LIM clocks without it the host goes idle with o_prog_err set.
module fsp_host #(
    parameter int P_WC_CYC = fsp_pkg::FSP_WC_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ld_valid,
    input wire logic [fsp_pkg::FSP_DATA_W-1:0] i_ld_data,
    output logic o_ld_ready,
    input wire logic i_prog_start,
    input wire logic [fsp_pkg::FSP_SEC_W-1:0] i_sector,
    input wire logic i_rd_start,
    input wire logic [fsp_pkg::FSP_ADDR_W-1:0] i_rd_addr,
    input wire logic i_id_start,
    input wire logic i_id_sel,
    output logic o_busy,
    output logic o_rd_valid,
    output logic [fsp_pkg::FSP_DATA_W-1:0] o_rd_data,
    output logic o_prog_done,
    output logic o_prog_err,
    output logic [fsp_pkg::FSP_ADDR_W-1:0] o_addr,
    output logic o_chip_select_n,
    output logic o_output_drive_n,
    output logic o_write_strobe_n,
    input wire logic [fsp_pkg::FSP_DATA_W-1:0] i_dq,
    output logic [fsp_pkg::FSP_DATA_W-1:0] o_dq,
    output logic o_dq_oe
);
    import fsp_pkg::*;

    typedef struct packed {
        fsp_state_t state;
        fsp_job_t job;
        logic [6:0] step;
        logic [FSP_TMR_W-1:0] tmr;
        logic [FSP_POLL_W-1:0] poll_cnt;
        logic [6:0] ld_ptr;
        logic [8:0] sector;
        logic id_sel;
        logic [14:0] usr_addr;
        logic [14:0] addr;
        logic [7:0] dq;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic prev6;
        logic have_prev;
        logic poll_end;
        logic [7:0] rd_data;
        logic rd_valid;
        logic done;
        logic err;
    } fsp_host_st_t;

    localparam fsp_host_st_t RST_ST = '{state: S_IDLE, job: J_READ,
        step: '0, tmr: '0, poll_cnt: '0, ld_ptr: '0, sector: '0,
        id_sel: 1'b0, usr_addr: '0, addr: '0, dq: '0, dq_oe: 1'b0,
        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, sync1: '0, sync2: '0,
        prev6: 1'b0, have_prev: 1'b0, poll_end: 1'b0, rd_data: '0,
        rd_valid: 1'b0, done: 1'b0, err: 1'b0};
    localparam logic [FSP_POLL_W-1:0] WC_LIM = FSP_POLL_W'(P_WC_CYC);

    fsp_host_st_t r;
    fsp_host_st_t n;
    fsp_op_t op;
    logic go;
    logic ld_take;
    logic [6:0] ofs;
    logic [7:0] buf_rdata;

    // ========================================================
    // one write of a three-write command sequence
    function automatic fsp_op_t cmd_wr(input logic [1:0] idx,
                                       input logic [7:0] code);
        fsp_op_t c;
        c.rd = 1'b0;
        c.addr = (idx == 2'h1) ? FSP_CMD_ADDR2 : FSP_CMD_ADDR1;
        c.data = (idx == 2'h0) ? FSP_CMD_DAT1 :
                 (idx == 2'h1) ? FSP_CMD_DAT2 : code;
        return c;
    endfunction

    // ========================================================
    // bus operation for a given job and step
    function automatic fsp_op_t op_of(input fsp_job_t job,
        input logic [6:0] step, input logic [8:0] sector,
        input logic id_sel, input logic [14:0] uaddr);
        fsp_op_t c;
        logic [6:0] k;
        c = '0;
        k = step - FSP_STEP_LOAD0;
        unique case (job)
            J_PROG: begin
                if (step < FSP_STEP_LOAD0) begin
                    c = cmd_wr(step[1:0], FSP_CMD_PROG); // [RULE3]
                end else if (step < FSP_STEP_POLL) begin
                    c.addr = {sector, k[5:0]}; // [RULE1]
                end else begin
                    c.rd = 1'b1;
                    c.addr = {sector, 6'h00}; // [RULE7]
                end
            end
            J_READ: begin
                c.rd = 1'b1;
                c.addr = uaddr;
            end
            J_ID: begin
                if (step < FSP_STEP_ID_RD) begin
                    c = cmd_wr(step[1:0], FSP_CMD_ID_ENTRY);
                end else if (step == FSP_STEP_ID_RD) begin
                    c.rd = 1'b1;
                    c.addr = {14'h0000, id_sel}; // [RULE9]
                end else begin
                    c = cmd_wr(k[1:0] - 2'h1, FSP_CMD_ID_EXIT); // [RULE10]
                end
            end
            default: c = '0;
        endcase
        return c;
    endfunction

    assign o_ld_ready = (r.state == S_IDLE) && (r.ld_ptr != FSP_BUF_FULL);
    assign ld_take = i_ld_valid && o_ld_ready;

    // ========================================================
    // sequencer next state
    always_comb begin
        n = r;
        go = 1'b0;
        n.rd_valid = 1'b0;
        n.done = 1'b0;
        n.sync1 = i_dq;
        n.sync2 = r.sync1;
        if (ld_take) begin
            n.ld_ptr = r.ld_ptr + 7'h01;
        end
        if (r.job == J_PROG && r.state != S_IDLE
            && r.poll_cnt != WC_LIM) begin
            n.poll_cnt = r.poll_cnt + 1'b1;
        end
        unique case (r.state)
            // commands are only taken here, so nothing overlaps a cycle
            S_IDLE: begin
                n.step = '0;
                n.poll_cnt = '0;
                n.have_prev = 1'b0;
                n.poll_end = 1'b0;
                if (i_prog_start && r.ld_ptr == FSP_BUF_FULL) begin // [RULE2]
                    n.job = J_PROG;
                    n.sector = i_sector;
                    n.err = 1'b0;
                    n.ld_ptr = '0;
                    go = 1'b1;
                end else if (i_rd_start) begin
                    n.job = J_READ;
                    n.usr_addr = i_rd_addr;
                    go = 1'b1;
                end else if (i_id_start) begin
                    n.job = J_ID;
                    n.id_sel = i_id_sel;
                    go = 1'b1;
                end
            end
            S_WSET: begin
                if (r.job == J_PROG && r.step >= FSP_STEP_LOAD0) begin
                    n.dq = buf_rdata;
                end
                n.we_n = 1'b0; // [RULE12]
                n.tmr = FSP_TMR_W'(FSP_WP_CYC - 1);
                n.state = S_WLOW;
            end
            S_WLOW: begin
                n.tmr = r.tmr - 1'b1;
                if (r.tmr == '0) begin
                    n.we_n = 1'b1;
                    n.ce_n = 1'b1;
                    n.tmr = FSP_TMR_W'(FSP_WPH_CYC - 1); // [RULE4]
                    n.state = S_WHIGH;
                end
            end
            S_WHIGH: begin
                n.tmr = r.tmr - 1'b1;
                if (r.tmr == '0) begin
                    n.dq_oe = 1'b0;
                    n.step = r.step + 7'h01;
                    if (r.job == J_ID && r.step == FSP_STEP_ID_LAST) begin
                        n.state = S_IDLE;
                        n.rd_valid = 1'b1;
                    end else begin
                        go = 1'b1;
                    end
                end
            end
            S_RLOW: begin
                n.tmr = r.tmr - 1'b1;
                if (r.tmr == '0) begin
                    n.ce_n = 1'b1;
                    n.oe_n = 1'b1;
                    n.tmr = FSP_TMR_W'(FSP_OEHP_CYC - 1);
                    n.state = S_RHIGH;
                    n.rd_data = r.sync2;
                    // only a change between two reads counts, never a level
                    if (r.job == J_PROG) begin
                        n.prev6 = r.sync2[FSP_TOGGLE_BIT]; // [RULE6]
                        n.have_prev = 1'b1;
                        n.poll_end = r.have_prev
                            && r.sync2[FSP_TOGGLE_BIT] == r.prev6; // [RULE11]
                    end
                end
            end
            S_RHIGH: begin
                n.tmr = r.tmr - 1'b1;
                if (r.tmr == '0) begin
                    if (r.job == J_READ) begin
                        n.state = S_IDLE;
                        n.rd_valid = 1'b1;
                    end else if (r.job == J_ID) begin
                        n.step = r.step + 7'h01;
                        go = 1'b1;
                    end else if (r.poll_end || r.poll_cnt == WC_LIM) begin
                        // on poll_end the last read already holds valid array data
                        n.state = S_IDLE;
                        n.done = 1'b1;
                        n.err = !r.poll_end;
                    end else begin
                        go = 1'b1;
                    end
                end
            end
            default: n = RST_ST;
        endcase
        // launch the operation of the (new) step
        op = op_of(n.job, n.step, n.sector, n.id_sel, n.usr_addr);
        if (go) begin
            n.addr = op.addr;
            n.ce_n = 1'b0;
            if (op.rd) begin
                // both strobes pulse together on every poll read
                n.oe_n = 1'b0; // [RULE5] [RULE12]
                n.dq_oe = 1'b0;
                n.tmr = FSP_TMR_W'(FSP_RLOW_CYC - 1);
                n.state = S_RLOW;
            end else begin
                n.dq = op.data;
                n.dq_oe = 1'b1;
                n.state = S_WSET;
            end
        end
    end

    assign ofs = n.step - FSP_STEP_LOAD0;

    // ========================================================
    // sector bytes waiting for the load phase
    fsp_buf u_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(ld_take),
        .i_waddr(r.ld_ptr[5:0]),
        .i_wdata(i_ld_data),
        .i_raddr(ofs[5:0]),
        .o_rdata(buf_rdata)
    );

    // ========================================================
    // state register; reset assumes the device is in normal read
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= RST_ST; // [RULE8]
        end else begin
            r <= n;
        end
    end

    // ========================================================
    // outputs
    assign o_busy = (r.state != S_IDLE); // [RULE13]
    assign o_rd_valid = r.rd_valid;
    assign o_rd_data = r.rd_data;
    assign o_prog_done = r.done;
    assign o_prog_err = r.err;
    assign o_addr = r.addr;
    assign o_chip_select_n = r.ce_n;
    assign o_output_drive_n = r.oe_n;
    assign o_write_strobe_n = r.we_n;
    assign o_dq = r.dq;
    assign o_dq_oe = r.dq_oe;

    // ========================================================
    // checks: cycles between byte load strobes
    logic [12:0] gap_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gap_q <= '0;
        end else if (r.job != J_PROG || r.step <= FSP_STEP_LOAD0
                     || r.step >= FSP_STEP_POLL
                     || $fell(o_write_strobe_n)) begin
            gap_q <= '0;
        end else if (gap_q != 13'h1FFF) begin
            gap_q <= gap_q + 13'h0001;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_load_strobes;
        !o_write_strobe_n |-> o_output_drive_n && !o_chip_select_n && o_dq_oe;
    endproperty
    a_load_strobes: assert property (p_load_strobes) // [RULE12]
        else $error("byte load with output drive active");

    property p_read_strobes;
        !o_output_drive_n |-> o_write_strobe_n && !o_dq_oe;
    endproperty
    a_read_strobes: assert property (p_read_strobes) // [RULE12]
        else $error("read with write strobe or data driven");

    property p_sector_addr;
        $fell(o_write_strobe_n) && r.job == J_PROG
            && r.step >= FSP_STEP_LOAD0
            |-> o_addr[14:6] == r.sector && o_addr[5:0] == ofs[5:0];
    endproperty
    a_sector_addr: assert property (p_sector_addr) // [RULE1]
        else $error("byte load outside target sector");

    property p_byte_gap;
        gap_q < 13'(FSP_BLC_CYC);
    endproperty
    a_byte_gap: assert property (p_byte_gap) // [RULE4]
        else $error("byte load gap too long");

    property p_full_load;
        $rose(o_busy) && r.job == J_PROG |-> $past(r.ld_ptr) == FSP_BUF_FULL;
    endproperty
    a_full_load: assert property (p_full_load) // [RULE2]
        else $error("program started without 64 bytes");

    property p_unlock_first;
        $rose(o_busy) && r.job == J_PROG
            |-> o_addr == FSP_CMD_ADDR1 && o_dq == FSP_CMD_DAT1
            ##1 !o_write_strobe_n;
    endproperty
    a_unlock_first: assert property (p_unlock_first) // [RULE3]
        else $error("program does not open with unlock");

    property p_poll_addr;
        r.job == J_PROG && !o_output_drive_n
            |-> o_addr == {r.sector, 6'h00}
            && ($fell(o_output_drive_n) || $stable(o_addr));
    endproperty
    a_poll_addr: assert property (p_poll_addr) // [RULE7]
        else $error("poll address moved");

    property p_id_addr;
        r.job == J_ID && !o_output_drive_n
            |-> o_addr == {14'h0000, r.id_sel};
    endproperty
    a_id_addr: assert property (p_id_addr) // [RULE9]
        else $error("id read at wrong address");

    property p_id_exit;
        r.job == J_ID && o_rd_valid |-> $past(o_dq) == FSP_CMD_ID_EXIT;
    endproperty
    a_id_exit: assert property (p_id_exit) // [RULE10]
        else $error("id result without exit sequence");

    property p_toggle_end;
        o_prog_done && !o_prog_err
            |-> o_rd_data[FSP_TOGGLE_BIT] == r.prev6 && r.have_prev;
    endproperty
    a_toggle_end: assert property (p_toggle_end) // [RULE11]
        else $error("completion without two equal toggle reads");

    property p_no_overlap;
        o_busy && $past(o_busy) |-> $stable(r.job) && $stable(r.sector);
    endproperty
    a_no_overlap: assert property (p_no_overlap) // [RULE13]
        else $error("job changed while busy");

    c_prog_ok: cover property (o_prog_done && !o_prog_err);
    c_prog_err: cover property (o_prog_done && o_prog_err);
    c_id_read: cover property (o_rd_valid && r.job == J_ID);
    c_plain_read: cover property (o_rd_valid && r.job == J_READ);
endmodule

// [fsp_host_tb.sv]
// self-checking bench for the flash sector program host
`timescale 1ns/1ps
module fsp_host_tb;
    import fsp_pkg::*;
    typedef struct {logic [14:0] a; logic [7:0] e;} fsp_row_t;
    logic i_clk, i_rst, i_ld_valid, i_prog_start, i_rd_start, i_id_start;
    logic i_id_sel, o_ld_ready, o_busy, o_rd_valid, o_prog_done, o_prog_err;
    logic [7:0] i_ld_data, o_rd_data, o_dq, dev_dq;
    logic [8:0] i_sector;
    logic [14:0] i_rd_addr, o_addr;
    logic o_chip_select_n, o_output_drive_n, o_write_strobe_n, o_dq_oe, viol;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    wire [7:0] bus_dq = o_dq_oe ? o_dq : dev_dq;
    fsp_row_t rows [6] = '{'{15'h0140, 8'h5A}, '{15'h0142, 8'h58},
        '{15'h017F, 8'h65}, '{15'h7FC0, 8'hC3}, '{15'h7FFF, 8'hFC},
        '{15'h0180, 8'hFF}};

    fsp_host #(.P_WC_CYC(2000)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_ld_valid(i_ld_valid), .i_ld_data(i_ld_data),
        .o_ld_ready(o_ld_ready), .i_prog_start(i_prog_start),
        .i_sector(i_sector), .i_rd_start(i_rd_start), .i_rd_addr(i_rd_addr),
        .i_id_start(i_id_start), .i_id_sel(i_id_sel), .o_busy(o_busy),
        .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
        .o_prog_done(o_prog_done), .o_prog_err(o_prog_err), .o_addr(o_addr),
        .o_chip_select_n(o_chip_select_n), .o_output_drive_n(o_output_drive_n),
        .o_write_strobe_n(o_write_strobe_n), .i_dq(bus_dq), .o_dq(o_dq),
        .o_dq_oe(o_dq_oe));
    fsp_flash_model u_mem (.i_addr(o_addr), .i_cs_n(o_chip_select_n),
        .i_oe_n(o_output_drive_n), .i_we_n(o_write_strobe_n), .i_dq(bus_dq),
        .o_dq(dev_dq), .o_viol(viol));

    // ========================================================
    // clock, and a hang limit well above the whole run
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("[ERR] run_length exp finish got hang");
            results();
        end
    end

    // ========================================================
    // comparisons and verdict
    task automatic chk8(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ========================================================
    // stimulus: valid held up across back-to-back bytes
    task automatic load(input int from, cnt, input logic [7:0] key);
        for (int i = from; i < from + cnt; i++) begin
            @(posedge i_clk);
            i_ld_valid <= 1'b1;
            i_ld_data <= 8'(i) ^ key;
        end
        @(posedge i_clk);
        i_ld_valid <= 1'b0;
    endtask
    task automatic prog(input logic [8:0] s);
        int n;
        @(posedge i_clk);
        i_prog_start <= 1'b1;
        i_sector <= s;
        @(posedge i_clk);
        i_prog_start <= 1'b0;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (!o_prog_done && n < 3000);
        chk1("prog_done", 1'b1, o_prog_done);
        chk1("prog_err", 1'b0, o_prog_err);
        chk1("prog_after_busy", 1'b1, n > 703);
        $display("program of sector %h done", s);
    endtask
    // read (id=0) or identification read (id=1); latency is fixed
    task automatic do_op(input logic id, input logic [14:0] a,
                         input logic [7:0] e);
        int n;
        @(posedge i_clk);
        i_rd_start <= !id;
        i_id_start <= id;
        i_id_sel <= a[0];
        i_rd_addr <= a;
        @(posedge i_clk);
        i_rd_start <= 1'b0;
        i_id_start <= 1'b0;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (!o_rd_valid && n < 100);
        chk8("op_latency", id ? 8'h40 : 8'h0A, n[7:0]);
        chk8("op_data", e, o_rd_data);
    endtask

    // ========================================================
    // main sequence
    initial begin
        i_rst = 1'b1;
        {i_ld_valid, i_prog_start, i_rd_start, i_id_start, i_id_sel} = '0;
        i_ld_data = 8'h00;
        i_sector = 9'h000;
        i_rd_addr = 15'h0000;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        chk1("ld_ready", 1'b1, o_ld_ready);
        chk1("busy", 1'b0, o_busy);
        chk1("cs_n", 1'b1, o_chip_select_n);
        chk1("we_n", 1'b1, o_write_strobe_n);
        $display("reset test done");
        // a program with a part-filled buffer must not start
        load(0, 3, 8'h5A);
        @(posedge i_clk);
        i_prog_start <= 1'b1;
        i_sector <= 9'h005;
        @(posedge i_clk);
        i_prog_start <= 1'b0;
        #1;
        chk1("short_prog_busy", 1'b0, o_busy);
        load(3, 61, 8'h5A);
        #1;
        chk1("ld_ready_full", 1'b0, o_ld_ready);
        prog(9'h005);
        // second program needs the unlock again; last sector
        load(0, 64, 8'hC3);
        prog(9'h1FF);
        foreach (rows[i])
            do_op(1'b0, rows[i].a, rows[i].e);
        $display("array read test done");
        do_op(1'b1, 15'h0000, 8'h3C);
        do_op(1'b1, 15'h0001, 8'hC3);
        do_op(1'b0, rows[2].a, rows[2].e);
        $display("identification test done");
        chk1("bus_viol", 1'b0, viol);
        results();
    end
endmodule

// [fsp_pkg.sv]
// package of constants and types for the flash sector program host
package fsp_pkg;

    // ========================================================
    // widths and sector geometry
    localparam int FSP_ADDR_W = 15;
    localparam int FSP_DATA_W = 8;
    localparam int FSP_SEC_W = 9;
    localparam int FSP_OFS_W = 6;
    localparam int FSP_SECTOR_BYTES = 64;
    localparam int FSP_TOGGLE_BIT = 6;

    // ========================================================
    // timing: figures in their own unit, counts derived at 20 MHz
    localparam int FSP_CLK_NS = 50;
    localparam int FSP_T_WP_NS = 200;
    localparam int FSP_T_WPH_NS = 200;
    localparam int FSP_T_ACC_NS = 250;
    localparam int FSP_T_OEHP_NS = 150;
    localparam int FSP_T_BLC_US = 150;
    localparam int FSP_T_WC_MS = 20;
    localparam int FSP_SYNC_CYC = 2;
    // least times round up
    localparam int FSP_WP_CYC = (FSP_T_WP_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
    localparam int FSP_WPH_CYC =
        (FSP_T_WPH_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
    localparam int FSP_ACC_CYC =
        (FSP_T_ACC_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
    localparam int FSP_OEHP_CYC =
        (FSP_T_OEHP_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
    // read strobe also covers the two-stage pin synchroniser
    localparam int FSP_RLOW_CYC = FSP_ACC_CYC + FSP_SYNC_CYC;
    // longest times round down
    localparam int FSP_BLC_CYC = (FSP_T_BLC_US * 1000) / FSP_CLK_NS;
    localparam int FSP_WC_CYC = (FSP_T_WC_MS * 1000000) / FSP_CLK_NS;
    localparam int FSP_TMR_W = 4;
    localparam int FSP_POLL_W = 20;

    // ========================================================
    // command codes of the software sequences
    localparam logic [14:0] FSP_CMD_ADDR1 = 15'h5555;
    localparam logic [14:0] FSP_CMD_ADDR2 = 15'h2AAA;
    localparam logic [7:0] FSP_CMD_DAT1 = 8'hAA;
    localparam logic [7:0] FSP_CMD_DAT2 = 8'h55;
    localparam logic [7:0] FSP_CMD_PROG = 8'hA0;
    localparam logic [7:0] FSP_CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] FSP_CMD_ID_EXIT = 8'hF0;

    // ========================================================
    // step numbers inside a job
    localparam logic [6:0] FSP_STEP_LOAD0 = 7'h03;
    localparam logic [6:0] FSP_STEP_POLL = 7'h43;
    localparam logic [6:0] FSP_STEP_ID_RD = 7'h03;
    localparam logic [6:0] FSP_STEP_ID_LAST = 7'h06;
    localparam logic [6:0] FSP_BUF_FULL = 7'h40;

    // ========================================================
    // state and job encodings
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WSET = 3'b001,
        S_WLOW = 3'b010,
        S_WHIGH = 3'b011,
        S_RLOW = 3'b100,
        S_RHIGH = 3'b101
    } fsp_state_t;

    typedef enum logic [1:0] {
        J_PROG = 2'b00,
        J_READ = 2'b01,
        J_ID = 2'b10
    } fsp_job_t;

    typedef struct packed {
        logic rd;
        logic [14:0] addr;
        logic [7:0] data;
    } fsp_op_t;

endpackage
